// >>> logic/od_map_pkg.sv
// Purpose: Shared constants and carriers for the object-dictionary map.
// Assumes: One 100 MHz clock; requests come from the SDO/PDO engine.
// Notes: Error codes are seen by the requester, so they carry fixed codes.
`default_nettype none
package od_map_pkg;
	// Clock and periodic snapshot timing.
	localparam int CLK_MHZ = 100;
	localparam int SNAPSHOT_US = 480;
	localparam int SNAPSHOT_CYCLES = SNAPSHOT_US * CLK_MHZ;
	// Fixed object indices.
	localparam logic [15:0] IDX_LIVE_ERR = 16'h2007;
	localparam logic [15:0] IDX_REMOTE_SEL = 16'h2008;
	localparam logic [15:0] IDX_SERIAL = 16'h2009;
	localparam logic [15:0] IDX_READBACK = 16'h200A;
	localparam logic [15:0] IDX_USER_BASE = 16'h2100;
	localparam logic [15:0] IDX_USER_TOP = 16'h3FFF;
	// Reset values and entry counts.
	localparam logic [15:0] REMOTE_SEL_RESET = 16'h00C7;
	localparam logic [7:0] SERIAL_ENTRIES = 8'h02;
	localparam logic [7:0] USER_TYPES_RW = 8'h0E;
	localparam logic [7:0] USER_TYPES_RO = 8'h06;
	// Subindex codes of a mapped user-register object and of the serial object.
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_FULL = 8'h01;
	localparam logic [7:0] SUB_UPPER = 8'h02;
	localparam logic [7:0] SUB_LOWER = 8'h03;
	localparam logic [7:0] SUB_U24 = 8'h04;
	localparam logic [7:0] SUB_SIGNED_24 = 8'h05;
	localparam logic [7:0] SUB_BYTE = 8'h06;
	localparam logic [7:0] SUB_SET_WORD = 8'h07;
	localparam logic [7:0] SUB_SET_UPPER = 8'h08;
	localparam logic [7:0] SUB_SET_LOWER = 8'h09;
	localparam logic [7:0] SUB_SET_BYTE = 8'h0A;
	localparam logic [7:0] SUB_CLR_WORD = 8'h0B;
	localparam logic [7:0] SUB_CLR_UPPER = 8'h0C;
	localparam logic [7:0] SUB_CLR_LOWER = 8'h0D;
	localparam logic [7:0] SUB_CLR_BYTE = 8'h0E;
	localparam logic [7:0] SUB_RX = 8'h01;
	localparam logic [7:0] SUB_TX = 8'h02;
	// Read-back word field positions.
	localparam int RB_LOW_SW = 0;
	localparam int RB_HIGH_SW = 4;
	localparam int RB_SSI_PINS = 8;
	localparam int RB_AUX = 14;
	// Bit-rate selection: codes below the limit are valid.
	localparam logic [3:0] RATE_CODE_LIMIT = 4'h9;
	localparam logic [3:0] RATE_CODE_1M = 4'h0;
	localparam logic [4:0] NODE_ID_AT_ZERO = 5'h10;
	// Answer codes of an access.
	typedef enum logic [2:0] {
		ERR_NONE = 3'h0,
		ERR_NO_OBJECT = 3'h1,
		ERR_NO_SUB = 3'h2,
		ERR_WRITE_ONLY = 3'h3,
		ERR_READ_ONLY = 3'h4
	} err_e;
	// One dictionary access request.
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] index;
		logic [7:0] sub;
		logic [31:0] wdata;
	} access_req_s;
	// One dictionary access answer.
	typedef struct packed {
		logic valid;
		err_e err;
		logic [31:0] rdata;
	} access_resp_s;
endpackage
`default_nettype wire

// >>> logic/pin_sync.sv
// Purpose: Three-stage synchroniser for a group of pin levels.
// Assumes: Pins change slowly compared with the clock.
// Notes: A new level is taken only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 8
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Pins and settled levels.
	input wire logic [W-1:0] pins_in,
	output logic [W-1:0] level_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] level;
	} sync_state_s;
	sync_state_s st, next_st;

	// Stage one feeds only stage two, so no gate sees a metastable bit.
	always_comb begin
		next_st = st;
		next_st.s1 = pins_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.level[i] = st.s3[i];
			end
		end
	end

	// State register.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level_out = st.level;
endmodule // pin_sync
`default_nettype wire

// >>> logic/od_register_map.sv
// Purpose: Object-dictionary access to fixed objects and user registers.
// Assumes: One request per cycle at most; the answer follows one cycle on.
// Notes: The user registers live here as an array of words.
`timescale 1ns/1ps
`default_nettype none
module od_register_map import od_map_pkg::*; #(
	parameter int NUM_REGS = 200,
	parameter int SNAP_CYCLES = SNAPSHOT_CYCLES
) (
	// Clock and reset.
	input wire logic REF_CLK_IN,
	input wire logic RESET_N_IN,
	// Dictionary access.
	input wire access_req_s REQ_IN,
	output access_resp_s RESP_OUT,
	// Bus error bits from the controller.
	input wire logic [15:0] CAN_ERR_BITS_IN,
	// Serial shifter side.
	input wire logic SSI_CONFIGURED_IN,
	input wire logic SSI_RX_VALID_IN,
	input wire logic [31:0] SSI_RX_WORD_IN,
	output logic [31:0] SSI_TX_WORD_OUT,
	output logic SSI_TX_ENABLE_OUT,
	// Pins.
	input wire logic [3:0] SWITCH_LOW_IN,
	input wire logic [3:0] SWITCH_HIGH_IN,
	input wire logic [3:0] SSI_PINS_IN,
	input wire logic [1:0] AUX_IN,
	// Derived settings.
	output logic [4:0] NODE_ID_OUT,
	output logic [3:0] BIT_RATE_SEL_OUT,
	output logic [31:0] REMOTE_INPUTS_OUT
);
	typedef struct packed {
		logic [16:0] snap_timer;
		logic [15:0] live_err;
		logic [15:0] remote_sel;
		logic [31:0] rx_word;
		logic [31:0] tx_word;
		logic tx_enable;
		logic [4:0] node_id;
		logic [3:0] rate_sel;
		logic [31:0] remote_inputs;
		access_resp_s resp;
	} map_state_s;
	map_state_s st, next_st;
	logic [31:0] user_reg [NUM_REGS];
	logic [13:0] pins_level;
	logic [15:0] readback;
	logic mem_we;
	logic [7:0] mem_addr;
	logic [31:0] mem_wdata;

	// Does user register n exist.
	function automatic logic reg_exists(input logic [7:0] n);
		return 32'(n) < NUM_REGS;
	endfunction

	// Registers that software may only read.
	function automatic logic reg_read_only(input logic [7:0] n);
		return n == 8'h03 || n == 8'h07 || n == 8'h08 || n == 8'h09;
	endfunction

	// Pin levels pass a synchroniser before anyone looks at them.
	pin_sync #(
		.W(14)
	) u_pins (
		.clk_in(REF_CLK_IN),
		.reset_n_in(RESET_N_IN),
		.pins_in({AUX_IN, SSI_PINS_IN, SWITCH_HIGH_IN, SWITCH_LOW_IN}),
		.level_out(pins_level)
	);

	// Read-back word; bits 12 and 13 stay zero.
	always_comb begin
		readback = '0;
		readback[RB_LOW_SW +: 4] = pins_level[3:0];
		readback[RB_HIGH_SW +: 4] = pins_level[7:4];
		readback[RB_SSI_PINS +: 4] = pins_level[11:8];
		readback[RB_AUX +: 2] = pins_level[13:12];
	end

	// Next state: timers, pins, serial port and the access decode.
	always_comb begin
		logic [7:0] n;
		logic [31:0] cur;
		logic is_user;
		n = 8'(REQ_IN.index - IDX_USER_BASE);
		is_user = REQ_IN.index >= IDX_USER_BASE
			&& REQ_IN.index <= IDX_USER_TOP;
		cur = reg_exists(n) ? user_reg[n] : 32'h0;
		next_st = st;
		mem_we = 1'b0;
		mem_addr = n;
		mem_wdata = cur;
		// A free-running snapshot keeps reads coherent within 480 us.
		if (32'(st.snap_timer) >= SNAP_CYCLES - 1) begin
			next_st.snap_timer = '0;
			next_st.live_err = CAN_ERR_BITS_IN;
		end else begin
			next_st.snap_timer = st.snap_timer + 17'h1;
		end
		// Low switch 0 stands for the sixteenth node.
		next_st.node_id = (pins_level[3:0] == 4'h0) ? NODE_ID_AT_ZERO
			: {1'b0, pins_level[3:0]};
		next_st.rate_sel = (pins_level[7:4] < RATE_CODE_LIMIT)
			? pins_level[7:4] : RATE_CODE_1M;
		next_st.remote_inputs = reg_exists(st.remote_sel[7:0])
			&& st.remote_sel[15:8] == 8'h00
			? user_reg[st.remote_sel[7:0]] : 32'h0;
		// The shifter is ignored entirely until the port is set up.
		next_st.tx_enable = SSI_CONFIGURED_IN;
		if (SSI_CONFIGURED_IN && SSI_RX_VALID_IN) begin
			next_st.rx_word = SSI_RX_WORD_IN;
		end
		// Access answer, one cycle after the request.
		next_st.resp.valid = REQ_IN.valid;
		next_st.resp.err = ERR_NONE;
		next_st.resp.rdata = '0;
		if (REQ_IN.valid) begin
			if (REQ_IN.index == IDX_LIVE_ERR) begin
				if (REQ_IN.sub != SUB_COUNT) begin
					next_st.resp.err = ERR_NO_SUB;
				end else if (REQ_IN.write) begin
					next_st.resp.err = ERR_READ_ONLY;
				end else begin
					next_st.resp.rdata = {16'h0, st.live_err};
				end
			end else if (REQ_IN.index == IDX_REMOTE_SEL) begin
				if (REQ_IN.sub != SUB_COUNT) begin
					next_st.resp.err = ERR_NO_SUB;
				end else if (REQ_IN.write) begin
					next_st.remote_sel = REQ_IN.wdata[15:0];
				end else begin
					next_st.resp.rdata = {16'h0, st.remote_sel};
				end
			end else if (REQ_IN.index == IDX_SERIAL) begin
				if (REQ_IN.sub == SUB_COUNT || REQ_IN.sub == SUB_RX) begin
					if (REQ_IN.write) begin
						next_st.resp.err = ERR_READ_ONLY;
					end else if (REQ_IN.sub == SUB_RX) begin
						next_st.resp.rdata = st.rx_word;
					end else begin
						next_st.resp.rdata = {24'h0, SERIAL_ENTRIES};
					end
				end else if (REQ_IN.sub == SUB_TX) begin
					if (REQ_IN.write) begin
						next_st.tx_word = REQ_IN.wdata;
					end else begin
						next_st.resp.rdata = st.tx_word;
					end
				end else begin
					next_st.resp.err = ERR_NO_SUB;
				end
			end else if (REQ_IN.index == IDX_READBACK) begin
				if (REQ_IN.sub != SUB_COUNT) begin
					next_st.resp.err = ERR_NO_SUB;
				end else if (REQ_IN.write) begin
					next_st.resp.err = ERR_READ_ONLY;
				end else begin
					next_st.resp.rdata = {16'h0, readback};
				end
			end else if (!is_user || REQ_IN.index[15:8] != 8'h21
				|| !reg_exists(n)) begin
				next_st.resp.err = ERR_NO_OBJECT;
			end else if (REQ_IN.sub > SUB_CLR_BYTE
				|| (reg_read_only(n) && REQ_IN.sub > SUB_BYTE)) begin
				next_st.resp.err = ERR_NO_SUB;
			end else if (!REQ_IN.write) begin
				// Reads: count, plain views, refusal of write-only ones.
				unique case (REQ_IN.sub)
					SUB_COUNT: next_st.resp.rdata = {24'h0,
						reg_read_only(n) ? USER_TYPES_RO
						: USER_TYPES_RW};
					SUB_FULL: next_st.resp.rdata = cur;
					SUB_UPPER: next_st.resp.rdata = {16'h0,
						cur[31:16]};
					SUB_LOWER: next_st.resp.rdata = {16'h0,
						cur[15:0]};
					SUB_U24: next_st.resp.rdata = {8'h0,
						cur[23:0]};
					SUB_SIGNED_24: next_st.resp.rdata = {{8{cur[23]}},
						cur[23:0]};
					SUB_BYTE: next_st.resp.rdata = {24'h0,
						cur[7:0]};
					default: next_st.resp.err = ERR_WRITE_ONLY;
				endcase
			end else if (REQ_IN.sub == SUB_COUNT || reg_read_only(n)) begin
				next_st.resp.err = ERR_READ_ONLY;
			end else begin
				// Writes other than the full word and the signed 24-bit view merge into the old word, so unaddressed bits hold.
				mem_we = 1'b1;
				unique case (REQ_IN.sub)
					SUB_FULL: mem_wdata = REQ_IN.wdata;
					SUB_UPPER: mem_wdata = {REQ_IN.wdata[15:0],
						cur[15:0]};
					SUB_LOWER: mem_wdata = {cur[31:16],
						REQ_IN.wdata[15:0]};
					SUB_U24: mem_wdata = {cur[31:24],
						REQ_IN.wdata[23:0]};
					SUB_SIGNED_24: mem_wdata = {{8{REQ_IN.wdata[23]}},
						REQ_IN.wdata[23:0]};
					SUB_BYTE: mem_wdata = {cur[31:8],
						REQ_IN.wdata[7:0]};
					SUB_SET_WORD: mem_wdata = cur | REQ_IN.wdata;
					SUB_SET_UPPER: mem_wdata = cur
						| {REQ_IN.wdata[15:0], 16'h0};
					SUB_SET_LOWER: mem_wdata = cur
						| {16'h0, REQ_IN.wdata[15:0]};
					SUB_SET_BYTE: mem_wdata = cur
						| {24'h0, REQ_IN.wdata[7:0]};
					SUB_CLR_WORD: mem_wdata = cur & ~REQ_IN.wdata;
					SUB_CLR_UPPER: mem_wdata = cur
						& ~{REQ_IN.wdata[15:0], 16'h0};
					SUB_CLR_LOWER: mem_wdata = cur
						& ~{16'h0, REQ_IN.wdata[15:0]};
					default: mem_wdata = cur
						& ~{24'h0, REQ_IN.wdata[7:0]};
				endcase
			end
		end
	end

	// State register.
	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			st <= '0;
			st.remote_sel <= REMOTE_SEL_RESET;
		end else begin
			st <= next_st;
		end
	end

	// User register storage.
	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				user_reg[i] <= 32'h0;
			end
		end else if (mem_we) begin
			user_reg[mem_addr] <= mem_wdata;
		end
	end

	assign RESP_OUT = st.resp;
	assign SSI_TX_WORD_OUT = st.tx_word;
	assign SSI_TX_ENABLE_OUT = st.tx_enable;
	assign NODE_ID_OUT = st.node_id;
	assign BIT_RATE_SEL_OUT = st.rate_sel;
	assign REMOTE_INPUTS_OUT = st.remote_inputs;

	// Checks.
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RESET_N_IN);

	logic is_user_req;
	assign is_user_req = REQ_IN.index[15:8] == 8'h21 && 32'(REQ_IN.index[7:0])
		< NUM_REGS && !reg_read_only(REQ_IN.index[7:0]);
	sequence s_req_read_sub(logic [7:0] s);
		REQ_IN.valid && !REQ_IN.write && is_user_req && REQ_IN.sub == s;
	endsequence

	property p_snapshot_period;
		$changed(st.live_err) |-> st.snap_timer == 17'h0;
	endproperty
	a_snapshot_period: assert property (p_snapshot_period)
		else $error("live error word changed off period");

	property p_live_ro;
		REQ_IN.valid && REQ_IN.write && REQ_IN.index == IDX_LIVE_ERR
			|=> RESP_OUT.err != ERR_NONE;
	endproperty
	a_live_ro: assert property (p_live_ro)
		else $error("write to live error object accepted");

	property p_sel_write;
		REQ_IN.valid && REQ_IN.write && REQ_IN.index == IDX_REMOTE_SEL
			&& REQ_IN.sub == SUB_COUNT
			|=> st.remote_sel == $past(REQ_IN.wdata[15:0]);
	endproperty
	a_sel_write: assert property (p_sel_write)
		else $error("selector write lost");

	property p_no_rx_unconfigured;
		!SSI_CONFIGURED_IN |=> $stable(st.rx_word);
	endproperty
	a_no_rx_unconfigured: assert property (p_no_rx_unconfigured)
		else $error("serial word captured while unconfigured");

	property p_tx_enable;
		SSI_CONFIGURED_IN |=> SSI_TX_ENABLE_OUT;
	endproperty
	a_tx_enable: assert property (p_tx_enable)
		else $error("transmit not enabled after configuration");

	// The id is zero until the first edge after reset loads it, so skip that one.
	property p_node_id;
		$past(RESET_N_IN) |-> NODE_ID_OUT != 5'h0
			&& NODE_ID_OUT <= NODE_ID_AT_ZERO;
	endproperty
	a_node_id: assert property (p_node_id)
		else $error("node id out of range");

	property p_absent_reg;
		REQ_IN.valid && REQ_IN.index >= IDX_USER_BASE
			&& REQ_IN.index <= IDX_USER_TOP
			&& 32'(REQ_IN.index - IDX_USER_BASE) >= NUM_REGS
			|=> RESP_OUT.valid && RESP_OUT.err == ERR_NO_OBJECT;
	endproperty
	a_absent_reg: assert property (p_absent_reg)
		else $error("absent register answered with data");

	property p_wo_read;
		s_req_read_sub(SUB_SET_WORD) or s_req_read_sub(SUB_CLR_BYTE)
			|=> RESP_OUT.err == ERR_WRITE_ONLY && !$past(mem_we);
	endproperty
	a_wo_read: assert property (p_wo_read)
		else $error("write-only subindex read not refused");

	logic [31:0] cur_word;
	assign cur_word = user_reg[mem_addr < 8'(NUM_REGS) ? mem_addr : 8'h0];
	property p_set_word;
		REQ_IN.valid && REQ_IN.write && is_user_req
			&& REQ_IN.sub == SUB_SET_WORD
			|=> user_reg[$past(mem_addr)]
			== ($past(cur_word) | $past(REQ_IN.wdata));
	endproperty
	a_set_word: assert property (p_set_word)
		else $error("set-bits write did not OR");

	property p_count_read;
		s_req_read_sub(SUB_COUNT) |=> RESP_OUT.rdata == 32'h0000000E;
	endproperty
	a_count_read: assert property (p_count_read)
		else $error("access type count wrong");
endmodule // od_register_map
`default_nettype wire

// >>> bench/od_master_model.sv
// Purpose: Requester model that issues dictionary accesses one at a time.
// Assumes: The map samples requests on the rising edge of the clock.
// Notes: Between requests the fields carry the inverse of the last ones.
`timescale 1ns/1ps
`default_nettype none
module od_master_model import od_map_pkg::*; (
	// Clock.
	input wire logic clk_in,
	// Access port.
	output access_req_s req_out,
	input wire access_resp_s resp_in
);
	// No request is pending at time zero.
	initial begin
		req_out = '0;
	end

	// Drive on the falling edge and hold over the taking edge. Then scramble
	// the fields and take the one-cycle answer, so that a map leaning
	// on stale request values is caught.
	task automatic access(input logic w, input logic [15:0] idx,
		input logic [7:0] sub, input logic [31:0] wd,
		output err_e err, output logic [31:0] rd, output logic seen);
		@(negedge clk_in);
		req_out = '{1'b1, w, idx, sub, wd};
		@(negedge clk_in);
		req_out = '{1'b0, ~w, ~idx, ~sub, ~wd};
		seen = resp_in.valid;
		err = resp_in.err;
		rd = resp_in.rdata;
	endtask
endmodule // od_master_model
`default_nettype wire

// >>> bench/testbench.sv
// Purpose: Self-checking bench for the object-dictionary map.
// Assumes: Map answers at the taking edge; the bench reads it at the next falling edge.
// Notes: A bench copy of the user registers gives every expected user-register value.
`timescale 1ns/1ps
`default_nettype none
module testbench import od_map_pkg::*;;
	localparam int SNAP = 16;
	localparam int NREG = 200;
	logic clk, rst_n, ssi_cfg, rx_valid, tx_en, w, seen;
	access_req_s req;
	access_resp_s resp;
	logic [15:0] can_err;
	logic [31:0] rx_word, tx_word, remote, rd, wd, tv;
	logic [3:0] sw_lo, sw_hi, pins, rate;
	logic [1:0] aux;
	logic [4:0] node;
	logic [7:0] s;
	logic [31:0] regs [NREG];
	err_e e;
	int errors, num_checks, seed, i, n;

	od_register_map #(.NUM_REGS(NREG), .SNAP_CYCLES(SNAP)) od_register_map_i (
		.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .REQ_IN(req), .RESP_OUT(resp),
		.CAN_ERR_BITS_IN(can_err), .SSI_CONFIGURED_IN(ssi_cfg),
		.SSI_RX_VALID_IN(rx_valid), .SSI_RX_WORD_IN(rx_word),
		.SSI_TX_WORD_OUT(tx_word), .SSI_TX_ENABLE_OUT(tx_en),
		.SWITCH_LOW_IN(sw_lo), .SWITCH_HIGH_IN(sw_hi), .SSI_PINS_IN(pins),
		.AUX_IN(aux), .NODE_ID_OUT(node), .BIT_RATE_SEL_OUT(rate),
		.REMOTE_INPUTS_OUT(remote));
	od_master_model od_master_model_i (.clk_in(clk), .req_out(req),
		.resp_in(resp));

	// Registers 3, 7, 8 and 9 are the read-only ones.
	function automatic logic is_ro(input int k);
		return k == 3 || k == 7 || k == 8 || k == 9;
	endfunction

	// Answer code that a user-register access must get.
	function automatic err_e exp_err(input int k, input logic wr,
		input logic [7:0] sb);
		if (sb > 8'h0E) return ERR_NO_SUB;
		if (sb >= SUB_SET_WORD) begin
			if (is_ro(k)) return ERR_NO_SUB;
			return wr ? ERR_NONE : ERR_WRITE_ONLY;
		end
		if (sb == SUB_COUNT || is_ro(k)) return wr ? ERR_READ_ONLY : ERR_NONE;
		return ERR_NONE;
	endfunction

	// New register value after an accepted write.
	function automatic logic [31:0] apply(input logic [31:0] o,
		input logic [7:0] sb, input logic [31:0] d);
		case (sb)
			8'h01: return d;
			8'h02: return {d[15:0], o[15:0]};
			8'h03: return {o[31:16], d[15:0]};
			8'h04: return {o[31:24], d[23:0]};
			8'h05: return {{8{d[23]}}, d[23:0]};
			8'h06: return {o[31:8], d[7:0]};
			8'h07: return o | d;
			8'h08: return o | {d[15:0], 16'h0000};
			8'h09: return o | {16'h0000, d[15:0]};
			8'h0A: return o | {24'h000000, d[7:0]};
			8'h0B: return o & ~d;
			8'h0C: return o & ~{d[15:0], 16'h0000};
			8'h0D: return o & ~{16'h0000, d[15:0]};
			default: return o & ~{24'h000000, d[7:0]};
		endcase
	endfunction

	// Value a read of one view returns.
	function automatic logic [31:0] view(input int k, input logic [7:0] sb);
		case (sb)
			8'h00: return is_ro(k) ? 32'h0000_0006 : 32'h0000_000E;
			8'h01: return regs[k];
			8'h02: return {16'h0000, regs[k][31:16]};
			8'h03: return {16'h0000, regs[k][15:0]};
			8'h04: return {8'h00, regs[k][23:0]};
			8'h05: return {{8{regs[k][23]}}, regs[k][23:0]};
			default: return {24'h000000, regs[k][7:0]};
		endcase
	endfunction

	// One comparison, counted; a mismatch is reported at once.
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One access through the requester with its expected answer.
	task automatic acc(input logic wr, input logic [15:0] idx,
		input logic [7:0] sb, input logic [31:0] d, input err_e ee,
		input logic [31:0] er);
		od_master_model_i.access(wr, idx, sb, d, e, rd, seen);
		chk("answer valid", 32'h0000_0001, {31'h0, seen});
		chk("answer code", {29'h0, ee}, {29'h0, e});
		chk("read data", er, rd);
	endtask

	// User-register access, keeping the bench copy up to date.
	task automatic uop(input logic wr, input int k, input logic [7:0] sb,
		input logic [31:0] d);
		err_e ee;
		ee = exp_err(k, wr, sb);
		acc(wr, IDX_USER_BASE + 16'(k), sb, d, ee,
			(ee == ERR_NONE && !wr) ? view(k, sb) : 32'h0);
		if (ee == ERR_NONE && wr) regs[k] = apply(regs[k], sb, d);
	endtask

	// Closing task for the normal end and for the watchdog.
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Watchdog: the run needs well under a tenth of this span.
	initial begin
		#200000;
		errors++;
		$display("watchdog expired");
		summarize();
	end

	// Main sequence; inputs change on the falling edge only.
	initial begin
		seed = 99105;
		{rst_n, ssi_cfg, rx_valid, can_err, rx_word} = '0;
		{sw_lo, sw_hi, pins, aux} = '0;
		for (i = 0; i < NREG; i++) regs[i] = 32'h0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		acc(0, IDX_REMOTE_SEL, 8'h00, 0, ERR_NONE, 32'h0000_00C7);
		acc(0, IDX_SERIAL, 8'h00, 0, ERR_NONE, 32'h0000_0002);
		uop(0, 3, SUB_COUNT, 0);
		uop(1, 12, SUB_COUNT, 1);
		uop(1, 10, SUB_SIGNED_24, 32'h0080_0001);
		uop(0, 10, SUB_FULL, 0);
		uop(1, NREG - 1, SUB_FULL, 32'hA5C3_0F81);
		uop(0, NREG - 1, SUB_U24, 0);
		chk("remote inputs", regs[NREG - 1], remote);
		acc(0, IDX_USER_BASE + 16'(NREG), 1, 0, ERR_NO_OBJECT, 0);
		acc(1, IDX_USER_TOP, 1, 1, ERR_NO_OBJECT, 0);
		$display("test corners done");
		for (i = 0; i < 400; i++) begin
			n = $unsigned($random(seed)) % 12;
			s = 8'($unsigned($random(seed)) % 16);
			w = 1'($random(seed));
			uop(w, n, s, $random(seed));
		end
		$display("test random access done");
		wd = $random(seed);
		uop(1, 5, SUB_FULL, wd);
		acc(1, IDX_REMOTE_SEL, 8'h00, 32'h5, ERR_NONE, 0);
		acc(0, IDX_REMOTE_SEL, 8'h00, 0, ERR_NONE, 32'h5);
		repeat (2) @(negedge clk);
		chk("remote inputs", regs[5], remote);
		$display("test selector done");
		for (i = 0; i < 6; i++) begin
			{sw_lo, sw_hi, pins, aux} = 14'($random(seed));
			if (i == 0) {sw_lo, sw_hi} = 8'h09;
			repeat (8) @(negedge clk);
			acc(0, IDX_READBACK, 8'h00, 0, ERR_NONE,
				{16'h0, aux, 2'b00, pins, sw_hi, sw_lo});
			chk("node id", (sw_lo == 0) ? 32'h0000_0010 : {28'h0, sw_lo},
				{27'h0, node});
			chk("bit rate", (sw_hi < 9) ? {28'h0, sw_hi} : 32'h0,
				{28'h0, rate});
		end
		acc(1, IDX_READBACK, 8'h00, 1, ERR_READ_ONLY, 0);
		$display("test readback done");
		can_err = 16'($random(seed));
		repeat (2 * SNAP + 2) @(negedge clk);
		acc(0, IDX_LIVE_ERR, 8'h00, 0, ERR_NONE, {16'h0, can_err});
		acc(1, IDX_LIVE_ERR, 8'h00, 1, ERR_READ_ONLY, 0);
		$display("test live errors done");
		tv = $random(seed);
		rx_word = $random(seed);
		rx_valid = 1'b1;
		@(negedge clk);
		rx_valid = 1'b0;
		acc(0, IDX_SERIAL, SUB_RX, 0, ERR_NONE, 0);
		acc(1, IDX_SERIAL, SUB_TX, tv, ERR_NONE, 0);
		chk("tx enable", 32'h0, {31'h0, tx_en});
		ssi_cfg = 1'b1;
		rx_word = ~tv;
		rx_valid = 1'b1;
		@(negedge clk);
		rx_valid = 1'b0;
		rx_word = tv;
		@(negedge clk);
		chk("tx enable", 32'h1, {31'h0, tx_en});
		chk("tx word", tv, tx_word);
		acc(0, IDX_SERIAL, SUB_RX, 0, ERR_NONE, ~tv);
		acc(1, IDX_SERIAL, SUB_RX, 1, ERR_READ_ONLY, 0);
		acc(0, IDX_SERIAL, SUB_TX, 0, ERR_NONE, tv);
		acc(1, IDX_SERIAL, 8'h00, 1, ERR_READ_ONLY, 0);
		acc(0, IDX_SERIAL, 8'h03, 0, ERR_NO_SUB, 0);
		acc(0, IDX_REMOTE_SEL, 8'h01, 0, ERR_NO_SUB, 0);
		ssi_cfg = 1'b0;
		@(negedge clk);
		chk("tx enable", 32'h0, {31'h0, tx_en});
		$display("test serial port done");
		summarize();
	end
endmodule // testbench
`default_nettype wire
